// [hw/psq_defines.svh]
// constants of the program sequencer: offsets, fields, vectors and timing
// assumes a single 40 MHz system clock and a 32-bit AXI4-Lite register port
//
// Summary of operation
// [RULE1] system clock runs through four phases; one instruction cycle is four clocks
// [RULE2] fetch in one instruction cycle, execute in the next, one per cycle
// [RULE3] any instruction changing the pointer takes two cycles, second is a dummy
// [RULE4] instruction pointer is 11 bits wide, covering 2048 program words
// [RULE5] after each fetch the pointer advances by one
// [RULE6] true skip discards the fetched instruction, resumes at address plus two
// [RULE7] low byte of the pointer is readable and writable at location 06h
// [RULE8] writing the low byte jumps within the page, upper three bits kept
// [RULE9] jump and call load the code's address; returns load the stack top
// [RULE10] reset and interrupt acknowledge load the fixed vector of that event
// [RULE11] wake from halt waits 1024 system clock periods before executing
// [RULE12] after reset fetching starts at address 000h
// [RULE13] acknowledged external interrupt vectors to 004h
// [RULE14] acknowledged time base interrupt vectors to 008h
// [RULE15] acknowledged timer/event counter interrupt vectors to 010h
// [RULE16] acknowledged real time clock interrupt vectors to 00ch
// [RULE17] simultaneous events: reset first, then lower vector addresses first
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH

// ***************************************************************
// register map (word index, byte address is four times the index)
// ***************************************************************
`define PSQ_IDX_COUNTER_LOW  6'h06
`define PSQ_IDX_STATUS       6'h10
`define PSQ_RESP_OKAY        2'b00
`define PSQ_RESP_SLVERR      2'b10

// ***************************************************************
// status register fields
// ***************************************************************
`define PSQ_ST_IP_LSB        0
`define PSQ_ST_SPCNT_LSB     12
`define PSQ_ST_HALTED_BIT    16
`define PSQ_ST_WARM_BIT      17
`define PSQ_ST_PEND_BIT      18

// ***************************************************************
// pointer, vectors and reset values
// ***************************************************************
`define PSQ_IP_W             11
`define PSQ_VEC_RESET        11'h000
`define PSQ_VEC_EXT          11'h004
`define PSQ_VEC_TBASE        11'h008
`define PSQ_VEC_RTC          11'h00c
`define PSQ_VEC_TIMER        11'h010
`define PSQ_PHASE_RESET      4'h1

// ***************************************************************
// timing
// ***************************************************************
`define PSQ_ACLK_PERIOD_NS   25
`define PSQ_SYS_PERIOD_NS    25
`define PSQ_STARTUP_PERIODS  1024
`define PSQ_STARTUP_CYC      ((`PSQ_STARTUP_PERIODS*`PSQ_SYS_PERIOD_NS+`PSQ_ACLK_PERIOD_NS-1)/`PSQ_ACLK_PERIOD_NS)
`define PSQ_PHASES           4

`endif

// [hw/psq_pkg.sv]
// types of the program sequencer
// assumes psq_defines.svh for numeric constants
package psq_pkg;
   typedef enum logic [2:0] {
      PSQ_OP_NEXT,
      PSQ_OP_SKIP,
      PSQ_OP_JUMP,
      PSQ_OP_CALL,
      PSQ_OP_RET,
      PSQ_OP_RETI
   } psq_op_t;

   typedef enum logic [1:0] {
      PSQ_RUN,
      PSQ_HALT,
      PSQ_WARM
   } psq_state_t;
endpackage

// [hw/psq_stack_mem.sv]
// return address store of the sequencer
// assumes one clock, registered read, write and read ports independent
`timescale 1ns/100ps
module psq_stack_mem #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 11
) (
   input  wire logic                     aclk,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   if (DEPTH < 2) begin : g_bad_depth
      $error("psq_stack_mem: DEPTH must be at least 2");
   end

   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // psq_stack_mem

// [hw/psq_program_sequencer.sv]
// program sequencer: phase generator, fetch pointer, stack, vectors, halt
// assumes decoder drives exec_op/exec_target/skip_true/halt_req for the
// instruction in execute, stable through its instruction cycle
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "psq_defines.svh"
module psq_program_sequencer #(
   parameter int IP_W        = `PSQ_IP_W, // RULE4
   parameter int STACK_DEPTH = 4
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [7:0]        araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  psq_pkg::psq_op_t       exec_op,
   input  wire logic [IP_W-1:0]   exec_target,
   input  wire logic              skip_true,
   input  wire logic              halt_req,
   input  wire logic              wake,
   input  wire logic [3:0]        int_req,
   input  wire logic [3:0]        int_enable,
   input  wire logic              int_global_en,
   output logic [3:0]             phase_clk,
   output logic [IP_W-1:0]        fetch_addr,
   output logic                   fetch_strobe,
   output logic                   exec_valid,
   output logic [3:0]             int_ack,
   output logic                   stack_full,
   output logic                   halted
);
   localparam int SP_W     = $clog2(STACK_DEPTH);
   localparam int WARM_CYC = `PSQ_STARTUP_CYC;
   localparam int WC_W     = $clog2(WARM_CYC);

   if (IP_W < 9 || IP_W > 16 || STACK_DEPTH != (1 << SP_W) || STACK_DEPTH < 2) begin : g_bad
      $error("psq_program_sequencer: unsupported IP_W or STACK_DEPTH");
   end

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [3:0] first_pend(input logic [3:0] p);
      return p & 4'(~p + 4'h1);
   endfunction

   function automatic logic [IP_W-1:0] vec_of(input logic [3:0] oh);
      logic [10:0] v;
      v = `PSQ_VEC_TIMER;
      if (oh[0]) v = `PSQ_VEC_EXT;
      else if (oh[1]) v = `PSQ_VEC_TBASE;
      else if (oh[2]) v = `PSQ_VEC_RTC;
      return IP_W'(v);
   endfunction

   // ***************************************************************
   // state
   // ***************************************************************
   psq_pkg::psq_state_t    state, next_state;
   logic [3:0]             next_phase_clk, next_int_ack;
   logic [IP_W-1:0]        ip, next_ip, next_fetch_addr;
   logic                   next_fetch_strobe, next_exec_valid, next_stack_full, next_halted;
   logic [WC_W-1:0]        wcnt, next_wcnt;
   logic [SP_W-1:0]        sp_ptr, next_sp_ptr;
   logic [SP_W:0]          sp_cnt, next_sp_cnt;
   logic                   pcl_pend, next_pcl_pend;
   logic [7:0]             pcl_data, next_pcl_data;
   logic                   was_xfer, next_was_xfer, seq_adv, next_seq_adv, sj_done, next_sj_done;
   logic                   push;
   logic [IP_W-1:0]        push_data, stack_top, f_addr;
   logic                   bnd, xfer;
   logic [3:0]             pend, grant;
   logic                   aw_got, next_aw_got, w_got, next_w_got, lane0, next_lane0;
   logic [5:0]             aw_idx, next_aw_idx;
   logic [7:0]             w_byte, next_w_byte;
   logic                   next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]             next_bresp, next_rresp;
   logic [31:0]            next_rdata;

   psq_stack_mem #(.DEPTH(STACK_DEPTH), .WIDTH(IP_W)) u_stack (
      .aclk    (aclk),
      .wr_en   (push),
      .wr_addr (sp_ptr),
      .wr_data (push_data),
      .rd_addr (sp_ptr - 1'b1),
      .rd_data (stack_top)
   );

   // ***************************************************************
   // sequencing
   // ***************************************************************
   always_comb begin
      bnd               = phase_clk[3] && state == psq_pkg::PSQ_RUN; // RULE1
      pend              = int_req & int_enable & {4{int_global_en}};
      grant             = first_pend(pend); // RULE17
      next_phase_clk    = {phase_clk[2:0], phase_clk[3]}; // RULE1
      next_state        = state;
      next_ip           = ip;
      next_fetch_addr   = fetch_addr;
      next_fetch_strobe = 1'b0;
      next_exec_valid   = exec_valid;
      next_int_ack      = 4'h0;
      next_wcnt         = wcnt;
      next_sp_ptr       = sp_ptr;
      next_sp_cnt       = sp_cnt;
      next_pcl_pend     = pcl_pend;
      next_pcl_data     = pcl_data;
      next_was_xfer     = was_xfer;
      next_seq_adv      = seq_adv;
      next_sj_done      = 1'b0;
      push              = 1'b0;
      push_data         = fetch_addr;
      xfer              = 1'b0;
      f_addr            = ip;
      unique case (state)
         psq_pkg::PSQ_RUN: begin
            if (bnd) begin
               if (exec_valid && exec_op != psq_pkg::PSQ_OP_NEXT) begin
                  unique case (exec_op)
                     psq_pkg::PSQ_OP_SKIP: begin
                        xfer   = skip_true; // RULE6
                        f_addr = ip;
                     end
                     psq_pkg::PSQ_OP_JUMP: begin
                        xfer   = 1'b1;
                        f_addr = exec_target; // RULE9
                     end
                     psq_pkg::PSQ_OP_CALL: begin
                        xfer   = 1'b1;
                        push   = 1'b1;
                        f_addr = exec_target; // RULE9
                     end
                     default: begin
                        xfer   = 1'b1;
                        f_addr = stack_top; // RULE9
                        if (sp_cnt != '0) next_sp_cnt = sp_cnt - 1'b1;
                        next_sp_ptr = sp_ptr - 1'b1;
                     end
                  endcase
               end else if (exec_valid && halt_req) begin
                  next_state      = psq_pkg::PSQ_HALT;
                  next_exec_valid = 1'b0;
               end else if (pcl_pend) begin
                  xfer          = 1'b1;
                  f_addr        = {ip[IP_W-1:8], pcl_data}; // RULE8
                  next_pcl_pend = 1'b0;
                  next_sj_done  = 1'b1;
               end else if (pend != 4'h0 && !stack_full) begin
                  xfer         = 1'b1;
                  push         = 1'b1;
                  f_addr       = vec_of(grant); // RULE10 RULE13 RULE14 RULE15 RULE16
                  next_int_ack = grant;
               end
               if (next_state == psq_pkg::PSQ_RUN) begin
                  if (!xfer || exec_op != psq_pkg::PSQ_OP_SKIP || !exec_valid) begin
                     f_addr = xfer ? f_addr : ip;
                  end
                  next_fetch_addr   = f_addr;
                  next_ip           = f_addr + 1'b1; // RULE5
                  next_fetch_strobe = 1'b1;
                  next_exec_valid   = !xfer; // RULE2 RULE3
                  next_was_xfer     = xfer;
                  next_seq_adv      = !xfer;
               end
               if (push) begin
                  next_sp_ptr = sp_ptr + 1'b1;
                  if (!stack_full) next_sp_cnt = sp_cnt + 1'b1;
               end
            end
         end
         psq_pkg::PSQ_HALT: begin
            if (wake) begin
               next_state = psq_pkg::PSQ_WARM;
               next_wcnt  = WC_W'(WARM_CYC - 1);
            end
         end
         psq_pkg::PSQ_WARM: begin
            if (wcnt != '0) begin
               next_wcnt = wcnt - 1'b1; // RULE11
            end else if (phase_clk[3]) begin
               next_state        = psq_pkg::PSQ_RUN;
               next_fetch_strobe = 1'b1;
               next_was_xfer     = 1'b1;
               next_seq_adv      = 1'b0;
            end
         end
      endcase
      next_stack_full = next_sp_cnt == (SP_W+1)'(STACK_DEPTH);
      next_halted     = next_state != psq_pkg::PSQ_RUN;
      if (aw_got && w_got && !bvalid && !pcl_pend && aw_idx == `PSQ_IDX_COUNTER_LOW && lane0) begin
         next_pcl_pend = 1'b1; // RULE8
         next_pcl_data = w_byte;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_clk    <= `PSQ_PHASE_RESET;
         state        <= psq_pkg::PSQ_RUN;
         fetch_addr   <= IP_W'(`PSQ_VEC_RESET); // RULE12
         ip           <= IP_W'(`PSQ_VEC_RESET) + 1'b1;
         fetch_strobe <= 1'b1;
         exec_valid   <= 1'b0;
         int_ack      <= 4'h0;
         wcnt         <= '0;
         sp_ptr       <= '0;
         sp_cnt       <= '0;
         stack_full   <= 1'b0;
         halted       <= 1'b0;
         pcl_pend     <= 1'b0;
         pcl_data     <= 8'h00;
         was_xfer     <= 1'b1;
         seq_adv      <= 1'b0;
         sj_done      <= 1'b0;
      end else begin
         phase_clk    <= next_phase_clk;
         state        <= next_state;
         fetch_addr   <= next_fetch_addr;
         ip           <= next_ip;
         fetch_strobe <= next_fetch_strobe;
         exec_valid   <= next_exec_valid;
         int_ack      <= next_int_ack;
         wcnt         <= next_wcnt;
         sp_ptr       <= next_sp_ptr;
         sp_cnt       <= next_sp_cnt;
         stack_full   <= next_stack_full;
         halted       <= next_halted;
         pcl_pend     <= next_pcl_pend;
         pcl_data     <= next_pcl_data;
         was_xfer     <= next_was_xfer;
         seq_adv      <= next_seq_adv;
         sj_done      <= next_sj_done;
      end
   end

   // ***************************************************************
   // axi4-lite slave
   // ***************************************************************
   always_comb begin
      next_aw_got  = aw_got;
      next_aw_idx  = aw_idx;
      next_w_got   = w_got;
      next_w_byte  = w_byte;
      next_lane0   = lane0;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      next_arready = arready;
      if (awvalid && awready) begin
         next_aw_got = 1'b1;
         next_aw_idx = awaddr[7:2];
      end
      if (wvalid && wready) begin
         next_w_got  = 1'b1;
         next_w_byte = wdata[7:0];
         next_lane0  = wstrb[0];
      end
      if (bvalid && bready) next_bvalid = 1'b0;
      if (aw_got && w_got && !bvalid && !pcl_pend) begin
         next_aw_got = 1'b0;
         next_w_got  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = aw_idx == `PSQ_IDX_COUNTER_LOW ? `PSQ_RESP_OKAY : `PSQ_RESP_SLVERR;
      end
      if (rvalid && rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
      if (arvalid && arready) begin
         next_rvalid  = 1'b1;
         next_arready = 1'b0;
         next_rresp   = `PSQ_RESP_OKAY;
         next_rdata   = 32'h0;
         if (araddr[7:2] == `PSQ_IDX_COUNTER_LOW) begin
            next_rdata[7:0] = ip[7:0]; // RULE7
         end else if (araddr[7:2] == `PSQ_IDX_STATUS) begin
            next_rdata[`PSQ_ST_IP_LSB +: IP_W]      = ip;
            next_rdata[`PSQ_ST_SPCNT_LSB +: SP_W+1] = sp_cnt;
            next_rdata[`PSQ_ST_HALTED_BIT]          = state == psq_pkg::PSQ_HALT;
            next_rdata[`PSQ_ST_WARM_BIT]            = state == psq_pkg::PSQ_WARM;
            next_rdata[`PSQ_ST_PEND_BIT]            = pcl_pend;
         end else begin
            next_rresp = `PSQ_RESP_SLVERR;
         end
      end
      next_awready = !next_aw_got;
      next_wready  = !next_w_got;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got  <= 1'b0;
         aw_idx  <= 6'h00;
         w_got   <= 1'b0;
         w_byte  <= 8'h00;
         lane0   <= 1'b0;
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= 2'h0;
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= 2'h0;
      end else begin
         aw_got  <= next_aw_got;
         aw_idx  <= next_aw_idx;
         w_got   <= next_w_got;
         w_byte  <= next_w_byte;
         lane0   <= next_lane0;
         awready <= next_awready;
         wready  <= next_wready;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_phase_rotate;
      phase_clk[0] |=> phase_clk[1] ##1 phase_clk[2] ##1 phase_clk[3] ##1 phase_clk[0];
   endproperty
   a_phase_rotate: assert property (p_phase_rotate) else $error("phase order broken"); // RULE1

   property p_seq_inc;
      fetch_strobe && seq_adv |-> fetch_addr == $past(fetch_addr, 4) + 1'b1;
   endproperty
   a_seq_inc: assert property (p_seq_inc) else $error("pointer did not advance by one"); // RULE5

   property p_dummy;
      bnd && was_xfer |-> !exec_valid;
   endproperty
   a_dummy: assert property (p_dummy) else $error("no dummy cycle after transfer"); // RULE3

   property p_reset_vec;
      !$past(aresetn) |-> fetch_addr == '0 && fetch_strobe;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset did not fetch 000h"); // RULE12

   property p_ext_vec;
      int_ack[0] |-> fetch_addr == IP_W'(`PSQ_VEC_EXT) && !exec_valid;
   endproperty
   a_ext_vec: assert property (p_ext_vec) else $error("external vector wrong"); // RULE13

   property p_tbase_vec;
      int_ack[1] |-> fetch_addr == IP_W'(`PSQ_VEC_TBASE) && !$past(pend[0]);
   endproperty
   a_tbase_vec: assert property (p_tbase_vec) else $error("time base vector wrong"); // RULE14

   property p_timer_vec;
      int_ack[3] |-> fetch_addr == IP_W'(`PSQ_VEC_TIMER) && $past(pend[2:0]) == 3'h0;
   endproperty
   a_timer_vec: assert property (p_timer_vec) else $error("timer vector wrong"); // RULE15

   property p_rtc_vec;
      int_ack[2] |-> fetch_addr == IP_W'(`PSQ_VEC_RTC) && $past(pend[1:0]) == 2'h0;
   endproperty
   a_rtc_vec: assert property (p_rtc_vec) else $error("rtc vector wrong"); // RULE16

   property p_short_jump;
      sj_done |-> fetch_addr == {$past(ip[IP_W-1:8]), $past(pcl_data)};
   endproperty
   a_short_jump: assert property (p_short_jump) else $error("short jump wrong"); // RULE8

   property p_jump;
      bnd && exec_valid && exec_op == psq_pkg::PSQ_OP_JUMP |=> fetch_addr == $past(exec_target);
   endproperty
   a_jump: assert property (p_jump) else $error("jump target not loaded"); // RULE9

   property p_warm_len;
      state == psq_pkg::PSQ_WARM && $past(state) == psq_pkg::PSQ_HALT
         |-> wcnt == WC_W'(WARM_CYC - 1) && !fetch_strobe;
   endproperty
   a_warm_len: assert property (p_warm_len) else $error("startup delay not loaded"); // RULE11

   property p_warm_exit;
      state == psq_pkg::PSQ_RUN && $past(state) == psq_pkg::PSQ_WARM |-> $past(wcnt) == '0;
   endproperty
   a_warm_exit: assert property (p_warm_exit) else $error("startup delay cut short"); // RULE11

   c_int: cover property (int_ack != 4'h0);
   c_skip: cover property (bnd && exec_valid && exec_op == psq_pkg::PSQ_OP_SKIP && skip_true);
   c_wake: cover property (state == psq_pkg::PSQ_WARM ##1 state == psq_pkg::PSQ_RUN);
   c_sj: cover property (sj_done);
endmodule // psq_program_sequencer

// [test/test_psq_program_sequencer.sv]
// bench of the program sequencer: sequencing, vectors, register bus, halt
// assumes the hw/ files compiled first and psq_defines.svh on the include path
`timescale 1ns/100ps
module test_psq_program_sequencer;
   logic             aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic             arvalid = 0, rready = 0, skip_true = 0, halt_req = 0, wake = 0;
   logic             int_global_en = 1, awready, wready, bvalid, arready, rvalid;
   logic             fetch_strobe, exec_valid, stack_full, halted;
   logic [7:0]       awaddr = 0, araddr = 0;
   logic [31:0]      wdata = 0, rdata, d;
   logic [3:0]       wstrb = 0, int_req = 0, phase_clk, int_ack;
   logic [1:0]       bresp, rresp, r;
   logic [10:0]      exec_target = 0, fetch_addr, prev, ra;
   psq_pkg::psq_op_t exec_op = psq_pkg::PSQ_OP_NEXT;
   int               fails = 0, tests_run = 0;
   logic [3:0]       rq [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hc, 4'h1};
   logic [10:0]      vc [5] = '{11'h004, 11'h008, 11'h00c, 11'h010, 11'h00c};

   psq_program_sequencer DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .exec_op, .exec_target, .skip_true, .halt_req, .wake, .int_req,
      .int_enable(4'hf), .int_global_en, .phase_clk, .fetch_addr, .fetch_strobe, .exec_valid,
      .int_ack, .stack_full, .halted);

   always #12.5 aclk = ~aclk;

   // ************************
   // shared tasks
   // ************************
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge aclk);
      #1;
   endtask
   task automatic to_phase(input logic [3:0] p);
      int n;
      n = 0;
      tick();
      while (phase_clk !== p && n < 8) begin
         tick();
         n++;
      end
   endtask
   // drives one execute slot, returns just after the boundary that takes it
   task automatic issue(input psq_pkg::psq_op_t op, input logic [10:0] t,
                        input logic [3:0] ir, input logic sk, input logic hr, input logic ge);
      prev = fetch_addr;
      @(posedge aclk);
      exec_op <= op;
      exec_target <= t;
      int_req <= ir;
      skip_true <= sk;
      halt_req <= hr;
      int_global_en <= ge;
      to_phase(4'h1);
   endtask
   task automatic nx();
      issue(psq_pkg::PSQ_OP_NEXT, 11'h0, 4'h0, 1'h0, 1'h0, 1'h1);
   endtask
   task automatic axw(input logic [7:0] a, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (n < 300) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'h0;
            n = 300;
         end
      end
   endtask
   task automatic axr(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (n < 300) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'h0;
            n = 300;
         end
      end
   endtask

   // ************************
   // scenarios
   // ************************
   task automatic t_reset();
      #1;
      check(fetch_addr, 32'h0);
      for (int k = 0; k < 4; k++) begin
         check(phase_clk, 4'h1 << k);
         tick();
      end
   endtask
   task automatic t_flow();
      for (int k = 0; k < 3; k++) begin
         nx();
         check({fetch_addr, exec_valid, fetch_strobe}, {prev + 11'h1, 2'h3});
      end
      issue(psq_pkg::PSQ_OP_JUMP, 11'h300, 4'h0, 1'h0, 1'h0, 1'h1);
      check({fetch_addr, exec_valid}, {11'h300, 1'h0});
      nx();
      check({fetch_addr, exec_valid}, {11'h301, 1'h1});
      issue(psq_pkg::PSQ_OP_SKIP, 11'h0, 4'h0, 1'h1, 1'h0, 1'h1);
      check({fetch_addr, exec_valid}, {11'h302, 1'h0});
      nx();
      issue(psq_pkg::PSQ_OP_CALL, 11'h123, 4'h0, 1'h0, 1'h0, 1'h1);
      check({fetch_addr, exec_valid}, {11'h123, 1'h0});
      nx();
      issue(psq_pkg::PSQ_OP_RET, 11'h0, 4'h0, 1'h0, 1'h0, 1'h1);
      check(fetch_addr, 11'h303);
      nx();
   endtask
   task automatic t_bus();
      axw(8'h18, 8'h5a);
      #1;
      if (phase_clk !== 4'h1) to_phase(4'h1);
      check({r, fetch_addr}, {2'h0, 11'h35a});
      axr(8'h18);
      check({r, fetch_addr}, {2'h0, 11'h35a});
      check(d, 32'h5b);
      axw(8'h7c, 8'h11);
      check(r, 2'h2);
      axw(8'h40, 8'h11);
      check(r, 2'h2);
      axr(8'h7c);
      check(r, 2'h2);
      to_phase(4'h1);
   endtask
   task automatic t_ints();
      for (int i = 0; i < 6; i++) begin
         issue(psq_pkg::PSQ_OP_NEXT, 11'h0, rq[i], 1'h0, 1'h0, i < 5);
         ra = prev;
         if (i < 5) check({int_ack, fetch_addr}, {rq[i] & -rq[i], vc[i]});
         else check({int_ack, fetch_addr}, {4'h0, prev + 11'h1});
         if (i < 5) begin
            nx();
            issue(psq_pkg::PSQ_OP_RETI, 11'h0, 4'h0, 1'h0, 1'h0, 1'h1);
            check(fetch_addr, ra);
            nx();
         end
      end
   endtask
   task automatic t_halt();
      int n;
      n = 0;
      issue(psq_pkg::PSQ_OP_NEXT, 11'h0, 4'h0, 1'h0, 1'h1, 1'h1);
      tick();
      check(halted, 1'h1);
      @(posedge aclk);
      halt_req <= 1'h0;
      wake <= 1'h1;
      while (halted === 1'h1 && n < 1200) begin
         tick();
         n++;
      end
      check(n >= 1023 && n <= 1032, 1'h1);
      @(posedge aclk);
      wake <= 1'h0;
   endtask

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_flow();
      t_bus();
      t_ints();
      t_halt();
      close_out();
   end
   initial begin
      #(25 * 80000);
      fails++;
      close_out();
   end
endmodule // test_psq_program_sequencer
